/* logic/czq_pkg.sv */
// package: constants, register map and carrier types of the cross-zone qualifier
package czq_pkg;

  localparam int          NUM_PAIRS     = 4;
  localparam int          ZONE_W        = 8;
  localparam logic [7:0]  ZONE_MAX      = 8'h80;
  localparam int          NUM_ZONES     = 129;
  localparam int          CLK_MHZ       = 200;
  localparam int          WINDOW_MIN    = 5;
  localparam longint      WINDOW_CYCLES = longint'(WINDOW_MIN) * 60 * 1000000 * CLK_MHZ;
  localparam int          TMR_W         = 37;
  localparam logic [7:0]  ERR_EVENT_CODE = 8'h00;
  localparam logic [11:0] CID_CODE      = 12'h378;

  // register byte offsets
  localparam logic [7:0] OFS_PAIR0     = 8'h00;
  localparam logic [7:0] OFS_RELAY     = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_MASK      = 8'h18;
  localparam logic [7:0] OFS_STATE     = 8'h1C;
  localparam logic [7:0] OFS_ERRCODE   = 8'h20;

  // pair register fields
  localparam int PAIR_ZA_LSB = 0;
  localparam int PAIR_ZB_LSB = 8;

  // status bit positions
  localparam int ST_QUAL_LSB = 0;
  localparam int ST_ERR_LSB  = 4;

  // reset values
  localparam logic [31:0] RST_PAIR  = 32'h0000_0000;
  localparam logic [3:0]  RST_RELAY = 4'h0;
  localparam logic [7:0]  RST_MASK  = 8'h00;

  typedef struct packed {
    logic [ZONE_W-1:0] zone_a;
    logic [ZONE_W-1:0] zone_b;
  } czq_pair_s;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } czq_apb_req_s;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_WAIT,
    PS_QUAL
  } czq_pstate_e;

endpackage

/* logic/czq_pair.sv */
// one cross-zone pair: window timer, qualification and error event
`timescale 1ns/1ps
module czq_pair
  import czq_pkg::*;
#(
  parameter longint WIN_CYCLES = WINDOW_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic skip,
  input  wire logic fault_a,
  input  wire logic fault_b,
  output logic      qualified,
  output logic      err_pulse,
  output logic      qual_pulse,
  output logic      both_restored
);

  typedef struct packed {
    czq_pstate_e      st;
    logic             first_a;
    logic [TMR_W-1:0] tmr;
    logic             qual;
    logic             err;
    logic             qp;
    logic             ep;
  } czq_pair_state_s;

  czq_pair_state_s r;
  czq_pair_state_s next_r;

  logic first_flt;
  logic second_flt;

  always_comb begin
    next_r    = r;
    next_r.qp = 1'b0;
    next_r.ep = 1'b0;
    first_flt  = r.first_a ? fault_a : fault_b;
    second_flt = r.first_a ? fault_b : fault_a;
    if (!enable || skip) begin
      next_r.st   = PS_IDLE;
      next_r.tmr  = '0;
      next_r.qual = 1'b0;
      next_r.err  = 1'b0;
    end else begin
      unique case (r.st)
        PS_IDLE: begin
          next_r.err = 1'b0;
          if (fault_a && fault_b) begin
            next_r.st   = PS_QUAL;
            next_r.qual = 1'b1;
            next_r.qp   = 1'b1;
          end else if (fault_a || fault_b) begin
            next_r.st      = PS_WAIT;
            next_r.first_a = fault_a;
            next_r.tmr     = '0;
          end
        end
        PS_WAIT: begin
          if (!first_flt) begin
            next_r.st  = PS_IDLE;
            next_r.tmr = '0;
          end else if (second_flt) begin
            next_r.st   = PS_QUAL;
            next_r.qual = 1'b1;
            next_r.qp   = 1'b1;
            next_r.tmr  = '0;
          end else if (r.tmr >= TMR_W'(WIN_CYCLES - 1)) begin
            next_r.st  = PS_IDLE;
            next_r.ep  = 1'b1;
            next_r.err = 1'b1;
            next_r.tmr = '0;
          end else begin
            next_r.tmr = r.tmr + TMR_W'(1);
          end
        end
        PS_QUAL: begin
          if (!fault_a && !fault_b) begin
            next_r.st   = PS_IDLE;
            next_r.qual = 1'b0;
          end
        end
      endcase
      // after an error hold idle one extra cycle; a lone fault still present then re-arms the window
      if (r.err && r.st == PS_IDLE && (fault_a || fault_b) && !(fault_a && fault_b)) begin
        next_r.st = PS_IDLE;
        next_r.tmr = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: PS_IDLE, first_a: 1'b0, tmr: '0, qual: 1'b0, err: 1'b0, qp: 1'b0, ep: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign qualified     = r.qual;
  assign err_pulse     = r.ep;
  assign qual_pulse    = r.qp;
  assign both_restored = !fault_a && !fault_b;

endmodule

/* logic/czq_top.sv */
// cross-zone alarm qualifier top: apb registers, zone decode, relays, interrupt
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module czq_top
  import czq_pkg::*;
#(
  parameter longint WIN_CYCLES = WINDOW_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_ZONES-1:0] zone_fault,
  input  wire logic [NUM_ZONES-1:0] zone_bypass,
  input  wire logic [NUM_ZONES-1:0] zone_type0,
  output logic      [NUM_ZONES-1:0] zone_alarm,
  output logic      [NUM_PAIRS-1:0] relay_fault,
  output logic      [NUM_PAIRS-1:0] relay_alarm,
  output logic                      err_report,
  output logic      [11:0]          err_code,
  output logic      [1:0]           err_pair,
  output logic                      irq
);

  typedef struct packed {
    czq_pair_s [NUM_PAIRS-1:0] pair;
    logic [NUM_PAIRS-1:0]      relay_mode;  // 1: deactivate on restore of both
    logic [7:0]                status;
    logic [7:0]                mask;
    logic [NUM_PAIRS-1:0]      relay_on;
    logic [31:0]               rdata;
    logic [NUM_ZONES-1:0]      alarm;
    logic [NUM_PAIRS-1:0]      rfault;
    logic                      erep;
    logic [1:0]                epair;
  } czq_top_state_s;

  czq_top_state_s r;
  czq_top_state_s next_r;

  // zone pin inputs pass two flip-flops before use
  logic [NUM_ZONES-1:0] flt_s1, flt_s2, byp_s1, byp_s2, t0_s1, t0_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_s1 <= '0;
      flt_s2 <= '0;
      byp_s1 <= '0;
      byp_s2 <= '0;
      t0_s1  <= '0;
      t0_s2  <= '0;
    end else begin
      flt_s1 <= zone_fault;
      flt_s2 <= flt_s1;
      byp_s1 <= zone_bypass;
      byp_s2 <= byp_s1;
      t0_s1  <= zone_type0;
      t0_s2  <= t0_s1;
    end
  end

  // zone number 001-128 maps to vector bit; 0 or above range never valid
  function automatic logic zone_valid(input logic [ZONE_W-1:0] z);
    return (z != '0) && (z <= ZONE_MAX);
  endfunction

  function automatic logic zone_bit(input logic [NUM_ZONES-1:0] v, input logic [ZONE_W-1:0] z);
    return zone_valid(z) ? v[z] : 1'b0;
  endfunction

  logic [NUM_PAIRS-1:0] p_en, p_skip, p_fa, p_fb, p_qual, p_err, p_qp, p_rest;
  logic [NUM_ZONES-1:0] crossed;

  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
      czq_pair #(
        .WIN_CYCLES(WIN_CYCLES)
      ) u_pair (
        .pclk         (pclk),
        .presetn      (presetn),
        .enable       (p_en[g]),
        .skip         (p_skip[g]),
        .fault_a      (p_fa[g]),
        .fault_b      (p_fb[g]),
        .qualified    (p_qual[g]),
        .err_pulse    (p_err[g]),
        .qual_pulse   (p_qp[g]),
        .both_restored(p_rest[g])
      );
    end
  endgenerate

  always_comb begin
    crossed = '0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      p_en[i]   = zone_valid(r.pair[i].zone_a) && zone_valid(r.pair[i].zone_b);
      p_skip[i] = zone_bit(byp_s2, r.pair[i].zone_a) || zone_bit(byp_s2, r.pair[i].zone_b)
                || zone_bit(t0_s2, r.pair[i].zone_a) || zone_bit(t0_s2, r.pair[i].zone_b);
      p_fa[i]   = zone_bit(flt_s2, r.pair[i].zone_a);
      p_fb[i]   = zone_bit(flt_s2, r.pair[i].zone_b);
      if (p_en[i] && !p_skip[i]) begin
        crossed[r.pair[i].zone_a] = 1'b1;
        crossed[r.pair[i].zone_b] = 1'b1;
      end
    end
  end

  logic       acc;
  logic       wr;
  logic       rd_ok;
  logic [7:0] err_ev;

  assign acc = psel && penable;
  assign wr  = acc && pwrite;

  always_comb begin
    err_ev = '0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      err_ev[ST_QUAL_LSB + i] = p_qp[i];
      err_ev[ST_ERR_LSB + i]  = p_err[i];
    end
  end

  always_comb begin
    next_r      = r;
    next_r.erep = 1'b0;
    rd_ok       = 1'b1;
    // uncrossed zones alarm on their own fault; crossed zones alarm only when qualified
    next_r.alarm = flt_s2 & ~crossed;
    next_r.alarm[0] = 1'b0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (p_en[i] && !p_skip[i] && p_qual[i]) begin
        next_r.alarm[r.pair[i].zone_a] = 1'b1;
        next_r.alarm[r.pair[i].zone_b] = 1'b1;
      end
      next_r.rfault[i] = p_fa[i] || p_fb[i];
      if (p_qp[i]) begin
        next_r.relay_on[i] = 1'b1;
      end else if (r.relay_on[i] && !p_qual[i]) begin
        if (!r.relay_mode[i] || p_rest[i]) begin
          next_r.relay_on[i] = 1'b0;
        end
      end
      if (!p_en[i] || p_skip[i]) begin
        next_r.relay_on[i] = 1'b0;
      end
    end
    for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
      if (p_err[i]) begin
        next_r.erep  = 1'b1;
        next_r.epair = 2'(i);
      end
    end
    // register writes
    if (wr) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        if (paddr == OFS_PAIR0 + 8'(4 * i)) begin
          if (pstrb[0]) next_r.pair[i].zone_a = pwdata[PAIR_ZA_LSB +: ZONE_W];
          if (pstrb[1]) next_r.pair[i].zone_b = pwdata[PAIR_ZB_LSB +: ZONE_W];
        end
      end
      if (paddr == OFS_RELAY && pstrb[0]) next_r.relay_mode = pwdata[NUM_PAIRS-1:0];
      if (paddr == OFS_MASK && pstrb[0]) next_r.mask = pwdata[7:0];
      if (paddr == OFS_STATUS && pstrb[0]) next_r.status = r.status & ~pwdata[7:0];
    end
    // hardware set wins over a write-one clear in the same cycle
    next_r.status = next_r.status | err_ev;
    // register reads
    next_r.rdata = '0;
    unique case (paddr)
      OFS_PAIR0, OFS_PAIR0 + 8'h04, OFS_PAIR0 + 8'h08, OFS_PAIR0 + 8'h0C: begin
        next_r.rdata = {16'h0000, r.pair[paddr[3:2]].zone_b, r.pair[paddr[3:2]].zone_a};
      end
      OFS_RELAY:   next_r.rdata = {28'h000_0000, r.relay_mode};
      OFS_STATUS:  next_r.rdata = {24'h00_0000, r.status};
      OFS_MASK:    next_r.rdata = {24'h00_0000, r.mask};
      OFS_STATE:   next_r.rdata = {20'h0_0000, p_skip, p_en, p_qual};
      OFS_ERRCODE: next_r.rdata = {20'h0_0000, CID_CODE};
      default: begin
        next_r.rdata = '0;
        rd_ok        = 1'b0;
      end
    endcase
    // read data is captured at the setup edge so it stands from a flop for the access cycle
    if (!(psel && !penable && !pwrite)) begin
      next_r.rdata = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PAIRS; i++) begin
        r.pair[i] <= RST_PAIR[15:0];
      end
      r.relay_mode <= RST_RELAY;
      r.status     <= '0;
      r.mask       <= RST_MASK;
      r.relay_on   <= '0;
      r.rdata      <= '0;
      r.alarm      <= '0;
      r.rfault     <= '0;
      r.erep       <= 1'b0;
      r.epair      <= '0;
    end else begin
      r <= next_r;
    end
  end

  // zero wait state slave; unmapped addresses answer with an error
  assign pready      = 1'b1;
  assign pslverr     = acc && !rd_ok;
  assign prdata      = r.rdata;
  assign zone_alarm  = r.alarm;
  assign relay_fault = r.rfault;
  assign relay_alarm = r.relay_on;
  assign err_report  = r.erep;
  assign err_code    = CID_CODE;
  assign err_pair    = r.epair;
  assign irq         = |(r.status & r.mask);

endmodule

/* testbench/czq_monitor.sv */
// checker: port timing relations of the cross-zone qualifier
`timescale 1ns/1ps
module czq_monitor
  import czq_pkg::*;
#(
  parameter longint WIN_CYCLES = WINDOW_CYCLES
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [7:0]           paddr,
  input wire logic                 pslverr,
  input wire logic [NUM_ZONES-1:0] zone_fault,
  input wire logic [NUM_ZONES-1:0] zone_alarm,
  input wire logic [NUM_PAIRS-1:0] relay_fault,
  input wire logic [NUM_PAIRS-1:0] relay_alarm,
  input wire logic                 err_report,
  input wire logic [11:0]          err_code,
  input wire logic [1:0]           err_pair
);
  longint cnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles that pair 0 has held a fault in either zone since the last error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt <= 0;
    else if (!relay_fault[0] || err_report)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  end

  a_code_const: assert property (err_code == 12'h378) else $error("bad error code");
  a_err_single: assert property (err_report |=> !err_report) else $error("error pulse too long");
  a_err_faulted: assert property (err_report |-> |($past(relay_fault) & (4'b0001 << err_pair)))
    else $error("error without fault");
  a_err_unqual: assert property (err_report |-> !relay_alarm[err_pair]) else $error("error on alarm");
  a_err_window: assert property (err_report && err_pair == 2'd0 |-> cnt >= WIN_CYCLES - 3 && cnt <= WIN_CYCLES + 3)
    else $error("error outside window");
  a_alarm_cause: assert property (!(|(zone_alarm & ~$past(zone_alarm) & ~($past(zone_fault, 2) | $past(zone_fault, 3)
    | $past(zone_fault, 4) | $past(zone_fault, 5))))) else $error("alarm without fault");
  a_zone_none: assert property (!zone_alarm[0]) else $error("zone zero alarm");
  a_relay_both: assert property (!(|(relay_alarm & ~$past(relay_alarm) & ~(relay_fault | $past(relay_fault)))))
    else $error("relay alarm without fault");
  a_slverr_map: assert property (psel && penable && paddr > 8'h20 |-> pslverr) else $error("no slave error");

  c_qual: cover property ($rose(relay_alarm[0]));
  c_err: cover property (err_report && err_pair == 2'd0);
  c_skip: cover property ($rose(zone_alarm[1]) && !relay_alarm[0]);
endmodule

bind czq_top czq_monitor #(.WIN_CYCLES(WIN_CYCLES)) u_czq_monitor (.pclk, .presetn, .psel, .penable, .paddr,
  .pslverr, .zone_fault, .zone_alarm, .relay_fault, .relay_alarm, .err_report, .err_code, .err_pair);

/* testbench/czq_zone_model.sv */
// partner model: zone sensors with fault, bypass and response-type levels
`timescale 1ns/1ps
module czq_zone_model (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         cmd_en,
  input  wire logic [1:0]   cmd_kind,
  input  wire logic [7:0]   cmd_zone,
  input  wire logic         cmd_val,
  output logic      [128:0] zone_fault,
  output logic      [128:0] zone_bypass,
  output logic      [128:0] zone_type0
);
  // pairs only join like zones of one area and partition, never entry/exit with follower
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zone_fault  <= '0;
      zone_bypass <= '0;
      zone_type0  <= '0;
    end else if (cmd_en) begin
      case (cmd_kind)
        2'd0: zone_fault[cmd_zone] <= cmd_val;
        2'd1: zone_bypass[cmd_zone] <= cmd_val;
        default: zone_type0[cmd_zone] <= cmd_val;
      endcase
    end
  end
endmodule

/* testbench/testbench.sv */
// testbench: apb programming, zone stimulus and queued result checks
`timescale 1ns/1ps
module testbench;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cmd_en = 0, cmd_val = 0;
  logic [7:0]   paddr = 0, cmd_zone = 0;
  logic [1:0]   cmd_kind = 0;
  logic [31:0]  pwdata = 0, prdata, rq[$], eq[$];
  logic         pready, pslverr, err_report, irq;
  logic [128:0] zone_fault, zone_bypass, zone_type0, zone_alarm;
  logic [3:0]   relay_fault, relay_alarm;
  logic [11:0]  err_code;
  logic [1:0]   err_pair;
  int           miscompares = 0, n_compared = 0, r;

  always #2.5 pclk = ~pclk;

  czq_top #(.WIN_CYCLES(20)) u_czq_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .zone_fault, .zone_bypass, .zone_type0, .zone_alarm, .relay_fault, .relay_alarm,
    .err_report, .err_code, .err_pair, .irq);
  czq_zone_model u_czq_zone_model (.pclk, .presetn, .cmd_en, .cmd_kind, .cmd_zone, .cmd_val, .zone_fault,
    .zone_bypass, .zone_type0);

  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_rd(input logic [31:0] g);
    check(rq.size() != 0 ? rq.pop_front() : 'x, g);
  endtask

  task automatic check_err(input logic [31:0] g);
    check(eq.size() != 0 ? eq.pop_front() : 'x, g);
  endtask

  task automatic stop_test;
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      stop_test;
    end else begin
      psel <= 0;
      penable <= 0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(0, a, 32'h0000_0000);
  endtask

  task automatic zset(input logic [1:0] k, input logic [7:0] z, input logic v);
    @(posedge pclk);
    cmd_en <= 1;
    cmd_kind <= k;
    cmd_zone <= z;
    cmd_val <= v;
    @(posedge pclk);
    cmd_en <= 0;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite)
      check_rd(prdata);
    if (err_report === 1'b1)
      check_err({30'h0, err_pair});
  end

  initial begin
    r = $urandom(32'h69a61721);
    wt(10);
    presetn <= 1;
    for (int i = 0; i < 9; i++) rd(8'(4 * i), i == 8 ? 32'h0000_0378 : 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    apb(1, 8'h00, 32'h0000_0201);
    apb(1, 8'h04, 32'h0000_0403);
    apb(1, 8'h0C, 32'h0000_8007);
    apb(1, 8'h10, 32'h0000_0001);
    apb(1, 8'h18, 32'h0000_00ff);
    rd(8'h0C, 32'h0000_8007);
    rd(8'h1C, 32'h0000_00b0);
    zset(0, 1, 1);
    wt(6);
    check(32'h1, {28'h0, relay_alarm[0], zone_alarm[2:1], relay_fault[0]});
    zset(0, 2, 1);
    wt(6);
    check(32'hf, {28'h0, relay_alarm[0], zone_alarm[2:1], irq});
    rd(8'h14, 32'h0000_0001);
    apb(1, 8'h14, 32'h0000_0001);
    rd(8'h14, 32'h0000_0000);
    zset(0, 1, 0);
    wt(6);
    check(32'h1, {31'h0, relay_alarm[0]});
    zset(0, 2, 0);
    wt(6);
    check(32'h0, {31'h0, relay_alarm[0]});
    eq.push_back(32'h0);
    zset(0, 1, 1);
    wt(30);
    zset(0, 1, 0);
    wt(6);
    rd(8'h14, 32'h0000_0010);
    check(32'h1, {31'h0, irq});
    apb(1, 8'h14, 32'h0000_0010);
    wt(2);
    check(32'h0, {31'h0, irq});
    repeat (2) begin
      zset(0, 1, 1);
      wt(14);
      zset(0, 1, 0);
      wt(4);
    end
    for (int k = 1; k < 3; k++) begin
      zset(2'(k), 1, 1);
      zset(0, 1, 1);
      wt(26);
      check(32'h2, {30'h0, zone_alarm[1], relay_alarm[0]});
      zset(0, 1, 0);
      zset(2'(k), 1, 0);
      wt(6);
    end
    zset(0, 3, 1);
    zset(0, 128, 1);
    zset(0, 5, 1);
    wt(6);
    check(32'h1, {29'h0, zone_alarm[3], zone_alarm[128], zone_alarm[5]});
    zset(0, 128, 0);
    zset(0, 4, 1);
    wt(6);
    check(32'h7, {29'h0, relay_alarm[1], zone_alarm[4:3]});
    zset(0, 3, 0);
    zset(0, 4, 0);
    zset(0, 5, 0);
    wt(5);
    check(32'h0, {30'h0, relay_alarm[1], zone_alarm[5]});
    repeat (4) begin
      r = 8 + int'($urandom % 120);
      zset(0, 8'(r), 1);
      wt(5);
      check(32'h1, {31'h0, zone_alarm[r]});
      zset(0, 8'(r), 0);
    end
    wt(5);
    check(32'h0, 32'(eq.size()));
    stop_test;
  end

  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    stop_test;
  end
endmodule
